// >>> ddr3_ctrl_pkg.sv
// constants, register map, field layouts and helper functions for the ddr3 init and refresh block
// assumes a 100 MHz system clock and a command path that accepts one command per cycle
`default_nettype none
package ddr3_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // minimum times round up, the refresh interval is an average and rounds down
  localparam int TXPR_NS = 170;
  localparam int TMRD_NS = 10;
  localparam int TMOD_NS = 15;
  localparam int TRFC_NS = 160;
  localparam int TREFI_NS = 7800;
  localparam int TXPR_CYC = (TXPR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMRD_CYC = (TMRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMOD_CYC = (TMOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRFC_CYC = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TREFI_CYC = TREFI_NS / CLK_PERIOD_NS;

  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CFG_W = 16;
  localparam int REF_W = 4;
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_MR0 = 8'h04;
  localparam logic [AW-1:0] OFS_MR1 = 8'h08;
  localparam logic [AW-1:0] OFS_MR2 = 8'h0c;
  localparam logic [AW-1:0] OFS_REF = 8'h10;
  localparam logic [AW-1:0] OFS_STAT = 8'h14;
  localparam logic [AW-1:0] OFS_MRS = 8'h18;

  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  localparam int MRS_PEND_BIT = 2;
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_BT_BIT = 2;
  localparam int MR0_CL_LSB = 3;
  localparam int MR0_WR_LSB = 7;
  localparam int MR0_PD_BIT = 10;
  localparam int MR1_ODI_LSB = 0;
  localparam int MR1_RTT_LSB = 2;
  localparam int MR1_AL_LSB = 5;
  localparam int MR2_CWL_LSB = 0;
  localparam int MR2_RTTWR_LSB = 3;

  localparam logic [CFG_W-1:0] MR0_CFG_RST = 16'h0220;
  localparam logic [CFG_W-1:0] MR1_CFG_RST = 16'h0004;
  localparam logic [CFG_W-1:0] MR2_CFG_RST = 16'h0001;
  localparam logic [REF_W-1:0] REF_BURST_RST = 4'h1;

  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_MRS = 2'h1;
  localparam logic [1:0] CMD_REF = 2'h2;

  // a burst count of zero still refreshes once, so memory is never starved
  function automatic logic [REF_W-1:0] burst_eff(input logic [REF_W-1:0] n);
    burst_eff = (n == 4'h0) ? 4'h1 : n;
  endfunction : burst_eff

  // init order of the mode registers: 2, 3, 1, 0
  function automatic logic [1:0] seq_ba(input logic [1:0] idx);
    case (idx)
      2'h0: seq_ba = 2'h2;
      2'h1: seq_ba = 2'h3;
      2'h2: seq_ba = 2'h1;
      default: seq_ba = 2'h0;
    endcase
  endfunction : seq_ba

  function automatic logic [15:0] mr0_word(input logic [CFG_W-1:0] c, input logic dll_rst);
    logic [15:0] w;
    w = 16'h0000;
    w[1:0] = c[MR0_BL_LSB +: 2];
    w[3] = c[MR0_BT_BIT];
    w[2] = c[MR0_CL_LSB];
    w[6:4] = c[MR0_CL_LSB+1 +: 3];
    w[8] = dll_rst;
    w[11:9] = c[MR0_WR_LSB +: 3];
    w[12] = c[MR0_PD_BIT];
    return w;
  endfunction : mr0_word

  function automatic logic [15:0] mr1_word(input logic [CFG_W-1:0] c);
    logic [15:0] w;
    w = 16'h0000;
    w[1] = c[MR1_ODI_LSB];
    w[5] = c[MR1_ODI_LSB+1];
    w[2] = c[MR1_RTT_LSB];
    w[6] = c[MR1_RTT_LSB+1];
    w[9] = c[MR1_RTT_LSB+2];
    w[4:3] = c[MR1_AL_LSB +: 2];
    return w;
  endfunction : mr1_word

  function automatic logic [15:0] mr2_word(input logic [CFG_W-1:0] c);
    logic [15:0] w;
    w = 16'h0000;
    w[5:3] = c[MR2_CWL_LSB +: 3];
    w[10:9] = c[MR2_RTTWR_LSB +: 2];
    return w;
  endfunction : mr2_word

  function automatic logic [CFG_W-1:0] be_merge(input logic [CFG_W-1:0] old,
      input logic [DW-1:0] wd, input logic [3:0] be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge
endpackage : ddr3_ctrl_pkg
`default_nettype wire

// >>> ddr3_init_mode_and_refresh_ctrl.sv
// ddr3 mode register initialisation and auto refresh control, avalon-mm register slave
// assumes banks are idle when refresh or mode register commands are issued
//
// What this block does
// - refresh as a back-to-back burst of N
// - internal mode: self-timed bursts, interval from N
// - init writes burst length, cas latency, type
// - init writes write recovery into mr0
// - init writes precharge power-down dll control
// - init writes drive, rtt_nom, additive latency
// - init writes cas write latency, rtt_wr
// - values hold until a later mode write
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module ddr3_init_mode_and_refresh_ctrl #(
  parameter int REFI_CYC = ddr3_ctrl_pkg::TREFI_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ddr3_ctrl_pkg::AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ddr3_ctrl_pkg::DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [ddr3_ctrl_pkg::DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_auto_ref_i,
  output logic cmd_valid_o,
  output logic [1:0] cmd_o,
  output logic [2:0] ba_o,
  output logic [15:0] addr_o,
  output logic init_done_o,
  output logic ref_busy_o
);
  import ddr3_ctrl_pkg::*;

  typedef enum {ST_IDLE, ST_WAIT, ST_MRS, ST_MRS_GAP, ST_READY, ST_REF, ST_REF_GAP} state_type;

  state_type state_reg, state_next;
  logic waitreq_reg, waitreq_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic ext_mode_reg, ext_mode_next;
  logic [CFG_W-1:0] mr0_cfg_reg, mr0_cfg_next, mr1_cfg_reg, mr1_cfg_next;
  logic [CFG_W-1:0] mr2_cfg_reg, mr2_cfg_next;
  logic [REF_W-1:0] ref_burst_reg, ref_burst_next, ref_left_reg, ref_left_next;
  logic [1:0] reprog_sel_reg, reprog_sel_next, idx_reg, idx_next;
  logic reprog_pend_reg, reprog_pend_next, ref_pend_reg, ref_pend_next;
  logic init_done_reg, init_done_next, ref_busy_reg, ref_busy_next;
  logic cmd_valid_reg, cmd_valid_next;
  logic [1:0] cmd_reg, cmd_next;
  logic [2:0] ba_reg, ba_next;
  logic [15:0] addr_reg, addr_next, wait_reg, wait_next;
  logic bus_wr, start, reprog_set, reprog_clr, ref_set, ref_clr, tick;
  logic [1:0] sel;

  ref_interval_timer #(.REFI_CYC(REFI_CYC)) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(init_done_reg && !ext_mode_reg),
    .burst_i(ref_burst_reg),
    .tick_o(tick)
  );

  function automatic logic [15:0] mrs_word(input logic [1:0] ba, input logic dll_rst,
      input logic [CFG_W-1:0] c0, input logic [CFG_W-1:0] c1, input logic [CFG_W-1:0] c2);
    case (ba)
      2'h0: mrs_word = mr0_word(c0, dll_rst);
      2'h1: mrs_word = mr1_word(c1);
      2'h2: mrs_word = mr2_word(c2);
      default: mrs_word = 16'h0000;
    endcase
  endfunction : mrs_word

  // register slave: one wait state, write lands on the edge that sees waitrequest low
  always_comb begin
    waitreq_next = !((avs_read_i || avs_write_i) && waitreq_reg);
    bus_wr = avs_write_i && !waitreq_reg;
    rdata_next = rdata_reg;
    ext_mode_next = ext_mode_reg;
    mr0_cfg_next = mr0_cfg_reg;
    mr1_cfg_next = mr1_cfg_reg;
    mr2_cfg_next = mr2_cfg_reg;
    ref_burst_next = ref_burst_reg;
    reprog_sel_next = reprog_sel_reg;
    start = 1'b0;
    reprog_set = 1'b0;
    if (avs_read_i && waitreq_reg) begin
      rdata_next = 32'h0000_0000;
      if (avs_address_i == OFS_CTRL) begin
        rdata_next[CTRL_EXT_BIT] = ext_mode_reg;
        rdata_next[CTRL_START_BIT] = (state_reg != ST_IDLE) && !init_done_reg;
      end else if (avs_address_i == OFS_MR0) begin
        rdata_next[CFG_W-1:0] = mr0_cfg_reg;
      end else if (avs_address_i == OFS_MR1) begin
        rdata_next[CFG_W-1:0] = mr1_cfg_reg;
      end else if (avs_address_i == OFS_MR2) begin
        rdata_next[CFG_W-1:0] = mr2_cfg_reg;
      end else if (avs_address_i == OFS_REF) begin
        rdata_next[REF_W-1:0] = ref_burst_reg;
      end else if (avs_address_i == OFS_STAT) begin
        rdata_next[STAT_DONE_BIT] = init_done_reg;
        rdata_next[STAT_BUSY_BIT] = ref_busy_reg;
        rdata_next[STAT_PEND_BIT] = ref_pend_reg;
      end else if (avs_address_i == OFS_MRS) begin
        rdata_next[1:0] = reprog_sel_reg;
        rdata_next[MRS_PEND_BIT] = reprog_pend_reg;
      end
    end
    if (bus_wr) begin
      if (avs_address_i == OFS_CTRL) begin
        if (avs_byteenable_i[0]) begin
          ext_mode_next = avs_writedata_i[CTRL_EXT_BIT];
          start = avs_writedata_i[CTRL_START_BIT] && (state_reg == ST_IDLE);
        end
      end else if (avs_address_i == OFS_MR0) begin
        mr0_cfg_next = be_merge(mr0_cfg_reg, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == OFS_MR1) begin
        mr1_cfg_next = be_merge(mr1_cfg_reg, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == OFS_MR2) begin
        mr2_cfg_next = be_merge(mr2_cfg_reg, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == OFS_REF) begin
        if (avs_byteenable_i[0]) begin
          ref_burst_next = avs_writedata_i[REF_W-1:0];
        end
      end else if (avs_address_i == OFS_MRS) begin
        // before init the full sequence will load the config anyway
        if (avs_byteenable_i[0] && init_done_reg) begin
          reprog_set = 1'b1;
          reprog_sel_next = avs_writedata_i[1:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      waitreq_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      ext_mode_reg <= 1'b0;
      mr0_cfg_reg <= MR0_CFG_RST;
      mr1_cfg_reg <= MR1_CFG_RST;
      mr2_cfg_reg <= MR2_CFG_RST;
      ref_burst_reg <= REF_BURST_RST;
      reprog_sel_reg <= 2'h0;
    end else begin
      waitreq_reg <= waitreq_next;
      rdata_reg <= rdata_next;
      ext_mode_reg <= ext_mode_next;
      mr0_cfg_reg <= mr0_cfg_next;
      mr1_cfg_reg <= mr1_cfg_next;
      mr2_cfg_reg <= mr2_cfg_next;
      ref_burst_reg <= ref_burst_next;
      reprog_sel_reg <= reprog_sel_next;
    end
  end

  // sequencer for init, refresh bursts and later mode writes
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    idx_next = idx_reg;
    ref_left_next = ref_left_reg;
    init_done_next = init_done_reg;
    cmd_valid_next = 1'b0;
    cmd_next = CMD_NOP;
    ba_next = ba_reg;
    addr_next = addr_reg;
    ref_clr = 1'b0;
    reprog_clr = 1'b0;
    sel = init_done_reg ? reprog_sel_reg : seq_ba(idx_reg);
    ref_set = init_done_reg && (ext_mode_reg ? ext_auto_ref_i : tick);
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          wait_next = 16'(TXPR_CYC - 1);
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_reg != 16'h0000) begin
          wait_next = wait_reg - 16'h0001;
        end else begin
          idx_next = 2'h0;
          state_next = ST_MRS;
        end
      end
      ST_MRS: begin
        cmd_valid_next = 1'b1;
        cmd_next = CMD_MRS;
        ba_next = {1'b0, sel};
        addr_next = mrs_word(sel, !init_done_reg, mr0_cfg_reg, mr1_cfg_reg, mr2_cfg_reg);
        wait_next = (init_done_reg || idx_reg == 2'h3) ? 16'(TMOD_CYC - 1) : 16'(TMRD_CYC - 1);
        state_next = ST_MRS_GAP;
      end
      ST_MRS_GAP: begin
        if (wait_reg != 16'h0000) begin
          wait_next = wait_reg - 16'h0001;
        end else if (init_done_reg || idx_reg == 2'h3) begin
          init_done_next = 1'b1;
          state_next = ST_READY;
        end else begin
          idx_next = idx_reg + 2'h1;
          state_next = ST_MRS;
        end
      end
      ST_READY: begin
        // refresh wins over a pending mode write so memory is never starved
        if (ref_pend_reg) begin
          ref_clr = 1'b1;
          ref_left_next = burst_eff(ref_burst_reg);
          state_next = ST_REF;
        end else if (reprog_pend_reg) begin
          reprog_clr = 1'b1;
          state_next = ST_MRS;
        end
      end
      ST_REF: begin
        cmd_valid_next = 1'b1;
        cmd_next = CMD_REF;
        ba_next = 3'h0;
        addr_next = 16'h0000;
        ref_left_next = ref_left_reg - 4'h1;
        wait_next = 16'(TRFC_CYC - 1);
        state_next = ST_REF_GAP;
      end
      default: begin
        if (wait_reg != 16'h0000) begin
          wait_next = wait_reg - 16'h0001;
        end else if (ref_left_reg != 4'h0) begin
          state_next = ST_REF;
        end else begin
          state_next = ST_READY;
        end
      end
    endcase
    // set wins over clear for both pending flags
    ref_pend_next = (ref_pend_reg && !ref_clr) || ref_set;
    reprog_pend_next = (reprog_pend_reg && !reprog_clr) || reprog_set;
    ref_busy_next = (state_next == ST_REF) || (state_next == ST_REF_GAP);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      wait_reg <= 16'h0000;
      idx_reg <= 2'h0;
      ref_left_reg <= 4'h0;
      init_done_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_reg <= CMD_NOP;
      ba_reg <= 3'h0;
      addr_reg <= 16'h0000;
      ref_pend_reg <= 1'b0;
      reprog_pend_reg <= 1'b0;
      ref_busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      idx_reg <= idx_next;
      ref_left_reg <= ref_left_next;
      init_done_reg <= init_done_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_reg <= cmd_next;
      ba_reg <= ba_next;
      addr_reg <= addr_next;
      ref_pend_reg <= ref_pend_next;
      reprog_pend_reg <= reprog_pend_next;
      ref_busy_reg <= ref_busy_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = waitreq_reg;
  assign cmd_valid_o = cmd_valid_reg;
  assign cmd_o = cmd_reg;
  assign ba_o = ba_reg;
  assign addr_o = addr_reg;
  assign init_done_o = init_done_reg;
  assign ref_busy_o = ref_busy_reg;

  // checking helpers: spacing, burst length, init order
  logic [15:0] gap_cnt;
  logic [1:0] last_cmd, mrs_cnt;
  logic [REF_W-1:0] ref_goal, ref_done;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_cnt <= 16'hffff;
      last_cmd <= CMD_NOP;
      mrs_cnt <= 2'h0;
      ref_goal <= 4'h0;
      ref_done <= 4'h0;
    end else begin
      gap_cnt <= cmd_valid_reg ? 16'h0001 : ((gap_cnt == 16'hffff) ? gap_cnt : gap_cnt + 16'h0001);
      if (cmd_valid_reg) last_cmd <= cmd_reg;
      if (cmd_valid_reg && cmd_reg == CMD_MRS && !init_done_reg) mrs_cnt <= mrs_cnt + 2'h1;
      if (state_reg == ST_READY && state_next == ST_REF) begin
        ref_goal <= ref_left_next;
        ref_done <= 4'h0;
      end else if (cmd_valid_reg && cmd_reg == CMD_REF) begin
        ref_done <= ref_done + 4'h1;
      end
    end
  end

  property p_ref_burst;
    @(posedge clk_i) disable iff (sys_rst_i) $fell(ref_busy_reg) |-> ref_done == ref_goal;
  endproperty
  a_ref_burst: assert property (p_ref_burst) else $error("refresh burst count wrong");
  property p_ref_gap;
    @(posedge clk_i) disable iff (sys_rst_i)
      cmd_valid_reg && last_cmd == CMD_REF |-> gap_cnt >= 16'(TRFC_CYC);
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("command too soon after refresh");
  property p_int_ref;
    @(posedge clk_i) disable iff (sys_rst_i) tick && !ext_mode_reg |=> ref_pend_reg;
  endproperty
  a_int_ref: assert property (p_int_ref) else $error("internal tick lost");
  property p_ext_quiet;
    @(posedge clk_i) disable iff (sys_rst_i)
      ext_mode_reg && !ext_auto_ref_i && !ref_pend_reg ##1 ext_mode_reg |-> !ref_pend_reg;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("refresh without request");
  property p_mr0_basic;
    @(posedge clk_i) disable iff (sys_rst_i) cmd_valid_reg && cmd_reg == CMD_MRS && ba_reg == 3'h0
      |-> addr_reg[1:0] == $past(mr0_cfg_reg[MR0_BL_LSB +: 2])
      && addr_reg[3] == $past(mr0_cfg_reg[MR0_BT_BIT])
      && {addr_reg[6:4], addr_reg[2]} == $past(mr0_cfg_reg[MR0_CL_LSB +: 4]);
  endproperty
  a_mr0_basic: assert property (p_mr0_basic) else $error("mr0 bl/cl/bt wrong");
  property p_mr0_wr;
    @(posedge clk_i) disable iff (sys_rst_i) cmd_valid_reg && cmd_reg == CMD_MRS && ba_reg == 3'h0
      |-> addr_reg[11:9] == $past(mr0_cfg_reg[MR0_WR_LSB +: 3]);
  endproperty
  a_mr0_wr: assert property (p_mr0_wr) else $error("mr0 write recovery wrong");
  property p_mr0_pd;
    @(posedge clk_i) disable iff (sys_rst_i) cmd_valid_reg && cmd_reg == CMD_MRS && ba_reg == 3'h0
      |-> addr_reg[12] == $past(mr0_cfg_reg[MR0_PD_BIT]) && addr_reg[8] == !init_done_reg;
  endproperty
  a_mr0_pd: assert property (p_mr0_pd) else $error("mr0 dll control wrong");
  property p_mr1;
    @(posedge clk_i) disable iff (sys_rst_i) cmd_valid_reg && cmd_reg == CMD_MRS && ba_reg == 3'h1
      |-> addr_reg == mr1_word($past(mr1_cfg_reg));
  endproperty
  a_mr1: assert property (p_mr1) else $error("mr1 value wrong");
  property p_mr2;
    @(posedge clk_i) disable iff (sys_rst_i) cmd_valid_reg && cmd_reg == CMD_MRS && ba_reg == 3'h2
      |-> addr_reg == mr2_word($past(mr2_cfg_reg));
  endproperty
  a_mr2: assert property (p_mr2) else $error("mr2 value wrong");
  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      // the pending flag drops as ready is left, one cycle before the command shows
      cmd_valid_reg && cmd_reg == CMD_MRS && init_done_reg |-> $past(reprog_pend_reg, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("unrequested mode write");
  property p_order;
    @(posedge clk_i) disable iff (sys_rst_i) cmd_valid_reg && cmd_reg == CMD_MRS && !init_done_reg
      |-> ba_reg == {1'b0, seq_ba(mrs_cnt)} && gap_cnt >= 16'(TMRD_CYC);
  endproperty
  a_order: assert property (p_order) else $error("init mrs order or gap wrong");
endmodule : ddr3_init_mode_and_refresh_ctrl
`default_nettype wire

// >>> ddr3_init_mode_and_refresh_ctrl_tb_top.sv
// self-checking bench: avalon-mm register access, init sequence and refresh
// assumes the memory model on the command port and REFI_CYC shortened to 20
`timescale 1ns/100ps
`default_nettype none
module ddr3_init_mode_and_refresh_ctrl_tb_top;
  import ddr3_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic ext_ref = 1'b0;
  logic cv;
  logic [1:0] cmd;
  logic [2:0] ba;
  logic [15:0] ma;
  logic idone;
  logic rbusy;
  logic [31:0] got;
  int n_fail = 0;
  int checks = 0;
  int r0;

  always #5 clk = ~clk;

  ddr3_init_mode_and_refresh_ctrl #(.REFI_CYC(20)) dut (.clk_i(clk), .sys_rst_i(rst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .ext_auto_ref_i(ext_ref), .cmd_valid_o(cv), .cmd_o(cmd), .ba_o(ba), .addr_o(ma),
    .init_done_o(idone), .ref_busy_o(rbusy));
  ddr3_mem_model mem (.clk_i(clk), .cmd_valid_i(cv), .cmd_i(cmd), .ba_i(ba), .addr_i(ma));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wait_for(input bit want_done, input bit lvl, input int lim);
    int n;
    n = 0;
    while (((want_done ? idone : rbusy) !== lvl) && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) chk(1'b1, 1'b0);
  endtask : wait_for

  task automatic t_reset_values();
    bus(1'b0, OFS_MR0, 32'h0);
    chk(got, 32'h0000_0220);
    bus(1'b0, OFS_REF, 32'h0);
    chk(got, 32'h0000_0001);
    bus(1'b0, 8'h1c, 32'h0);
    chk(got, 32'h0);
    chk(idone, 1'b0);
  endtask : t_reset_values

  task automatic t_init();
    bus(1'b1, OFS_MR0, 32'h0555);
    bus(1'b1, OFS_MR1, 32'h0055);
    bus(1'b1, OFS_MR2, 32'h001d);
    // external refresh mode and start together keeps the timer quiet
    bus(1'b1, OFS_CTRL, 32'h3);
    wait_for(1'b1, 1'b1, 200);
    chk(mem.mr[0], 16'h1559);
    chk(mem.mr[1], 16'h0216);
    chk(mem.mr[2], 16'h0628);
    chk(mem.mr[3], 16'h0000);
    chk({mem.ord[0], mem.ord[1], mem.ord[2], mem.ord[3]}, 12'o2310);
    chk(mem.n_mrs, 4);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(got, 32'h0000_0001);
  endtask : t_init

  task automatic t_ext_refresh();
    bus(1'b1, OFS_REF, 32'h3);
    r0 = mem.n_ref;
    repeat (100) @(posedge clk);
    chk(mem.n_ref - r0, 0);
    ext_ref <= 1'b1;
    @(posedge clk);
    ext_ref <= 1'b0;
    wait_for(1'b0, 1'b1, 20);
    wait_for(1'b0, 1'b0, 100);
    chk(mem.n_ref - r0, 3);
  endtask : t_ext_refresh

  task automatic t_int_refresh();
    bus(1'b1, OFS_REF, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h0);
    r0 = mem.n_ref;
    repeat (200) @(posedge clk);
    wait_for(1'b0, 1'b0, 100);
    // four bursts of two fit the window at 40 cycles each; 20 would give more
    chk((mem.n_ref - r0) >= 6 && (mem.n_ref - r0) <= 8, 1'b1);
    chk((mem.n_ref - r0) % 2, 0);
    bus(1'b1, OFS_CTRL, 32'h1);
    wait_for(1'b0, 1'b0, 100);
  endtask : t_int_refresh

  task automatic t_mode_hold();
    bus(1'b1, OFS_MR0, 32'h0000);
    bus(1'b1, OFS_MR2, 32'h0002);
    repeat (30) @(posedge clk);
    chk(mem.n_mrs, 4);
    chk(mem.mr[2], 16'h0628);
    bus(1'b1, OFS_MRS, 32'h2);
    repeat (40) @(posedge clk);
    chk(mem.mr[2], 16'h0010);
    chk(mem.mr[0], 16'h1559);
    bus(1'b0, OFS_MRS, 32'h0);
    chk(got, 32'h0000_0002);
    // rewrite of mr0 after init leaves dll reset off
    bus(1'b1, OFS_MRS, 32'h0);
    repeat (40) @(posedge clk);
    chk(mem.mr[0], 16'h0000);
    chk(mem.n_mrs, 6);
    chk(mem.n_err, 0);
  endtask : t_mode_hold

  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_init();
    t_ext_refresh();
    t_int_refresh();
    t_mode_hold();
    report_and_stop();
  end

  initial begin
    #30000;
    n_fail++;
    report_and_stop();
  end
endmodule : ddr3_init_mode_and_refresh_ctrl_tb_top
`default_nettype wire

// >>> ddr3_mem_model.sv
// behavioural ddr3 device: latches mode register writes, counts refreshes
// assumes one command per cycle from the controller, all banks idle
`timescale 1ns/100ps
`default_nettype none
module ddr3_mem_model (
  input wire logic clk_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i
);
  logic [15:0] mr [0:3];
  logic [2:0] ord [0:7];
  int n_mrs = 0;
  int n_ref = 0;
  int n_err = 0;
  int cyc = 0;
  int last_t = -100;
  logic [1:0] last_c = 2'h0;
  always @(posedge clk_i) begin
    cyc++;
    if (cmd_valid_i === 1'b1) begin
      // too close after a previous command breaks the device timing
      if ((last_c == 2'h1 && cyc - last_t < 2) || (last_c == 2'h2 && cyc - last_t < 17)) begin
        n_err++;
      end
      if (cmd_i == 2'h1) begin
        mr[ba_i[1:0]] = addr_i;
        ord[n_mrs % 8] = ba_i;
        n_mrs++;
      end else if (cmd_i == 2'h2) begin
        n_ref++;
      end
      last_t = cyc;
      last_c = cmd_i;
    end
  end
endmodule : ddr3_mem_model
`default_nettype wire

// >>> ref_interval_timer.sv
// refresh interval timer: one tick per burst interval
// assumes the burst count is stable while running; a change alters the running interval at once
`timescale 1ns/100ps
`default_nettype none
module ref_interval_timer #(
  parameter int REFI_CYC = ddr3_ctrl_pkg::TREFI_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [ddr3_ctrl_pkg::REF_W-1:0] burst_i,
  output logic tick_o
);
  import ddr3_ctrl_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] period;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    period = 16'(32'(burst_eff(burst_i)) * REFI_CYC);
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run_i) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg >= period - 16'h0001) begin
      cnt_next = 16'h0000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule : ref_interval_timer
`default_nettype wire
